/* File: logic/iox_exec.sv */
`timescale 1ns/100ps
`include "iox_defines.svh"

module iox_exec (
    input wire logic ref_clk, // Core clock, 100 MHz
    input wire logic sys_rst, // Async reset, high
    input wire logic ce, // Clock enable, freezes state
    input wire iox_pkg::iox_instr_s instr, // Word from fetch
    output logic [4:0] rd_addr, // File read address
    output logic [7:0] acc, // Accumulator
    output logic nil_flag, // Result-nil status flag
    output logic skip, // High during the no-op slot
    output logic retire, // Pulse per executed word and per no-op slot
    output iox_pkg::iox_fwr_s fwr // File write, registered
);

    // ----------------------------------------------------------------
    // Decode helper
    // ----------------------------------------------------------------
    function automatic iox_pkg::iox_op_e decode(input logic [11:0] w);
        if ((w & `IOX_INCSKIP_MASK) == `IOX_INCSKIP_PAT) begin
            return iox_pkg::IOX_OP_INCSKIP;
        end else if ((w & `IOX_ORLIT_MASK) == `IOX_ORLIT_PAT) begin
            return iox_pkg::IOX_OP_ORLIT;
        end else if ((w & `IOX_ORREG_MASK) == `IOX_ORREG_PAT) begin
            return iox_pkg::IOX_OP_ORREG;
        end else begin
            return iox_pkg::IOX_OP_OTHER;
        end
    endfunction : decode

    // Result-nil test shared by the OR operations and the skip
    function automatic logic is_nil(input logic [7:0] v);
        return (v == 8'h00);
    endfunction : is_nil

    // Bitwise inclusive OR of the accumulator and one operand
    function automatic logic [7:0] or_byte(input logic [7:0] a,
        input logic [7:0] b);
        return a | b;
    endfunction : or_byte

    // Eight-bit increment; the carry out is dropped on purpose
    function automatic logic [7:0] inc_byte(input logic [7:0] v);
        logic [8:0] sum;
        sum = {1'b0, v} + 9'h001;
        return sum[7:0];
    endfunction : inc_byte

    // ----------------------------------------------------------------
    // Pipeline state and architectural registers
    // ----------------------------------------------------------------
    // Two-stage pipe: stage 1 reads file, stage 2 executes
    typedef enum logic [0:0] {
        IOX_RUN = 1'b0,
        IOX_SKIP = 1'b1
    } iox_state_e;

    iox_state_e state_q, state_d;
    iox_pkg::iox_instr_s ex_q, ex_d;
    iox_pkg::iox_fwr_s fwr_q, fwr_d;
    logic [7:0] acc_q, acc_d;
    logic nil_q, nil_d;
    logic retire_q, retire_d;
    logic [7:0] file_data; // File word for the word in execute
    logic [7:0] result; // Result of the word in execute
    logic res_nil; // Result is all zeros
    logic do_exec; // Execute slot holds a live word
    logic wr_acc; // Result goes to the accumulator
    logic wr_file; // Result goes back to the file
    logic take_skip; // Wrapped increment, drop the follower
    logic dest_sel; // Target select bit of the word
    logic [4:0] fld_addr; // File address field
    logic [7:0] fld_lit; // Literal field
    iox_pkg::iox_op_e op;

    // ----------------------------------------------------------------
    // Operand fields of the word in execute
    // ----------------------------------------------------------------
    assign dest_sel = ex_q.word[`IOX_DEST_BIT];
    assign fld_addr = ex_q.word[`IOX_ADDR_MSB:0];
    assign fld_lit = ex_q.word[`IOX_LIT_MSB:0];
    assign op = decode(ex_q.word);

    // ----------------------------------------------------------------
    // File storage
    // ----------------------------------------------------------------
    iox_file_mem u_mem (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .rd_addr(instr.word[`IOX_ADDR_MSB:0]),
        .rd_data(file_data),
        .wr(fwr_d)
    );

    // ----------------------------------------------------------------
    // Operation datapath
    // ----------------------------------------------------------------
    // Result and destination of the word in execute
    always_comb begin
        result = 8'h00;
        res_nil = 1'b0;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        take_skip = 1'b0;
        do_exec = ex_q.valid && (state_q == IOX_RUN);
        case (op)
            iox_pkg::IOX_OP_INCSKIP: begin
                result = inc_byte(file_data);
                wr_acc = !dest_sel;
                wr_file = dest_sel;
                take_skip = is_nil(result);
            end
            iox_pkg::IOX_OP_ORLIT: begin
                result = or_byte(acc_q, fld_lit);
                wr_acc = 1'b1;
            end
            iox_pkg::IOX_OP_ORREG: begin
                result = or_byte(acc_q, file_data);
                wr_acc = !dest_sel;
                wr_file = dest_sel;
            end
            default: begin
                result = 8'h00;
            end
        endcase
        res_nil = is_nil(result);
    end

    // ----------------------------------------------------------------
    // Pipeline control
    // ----------------------------------------------------------------
    // Only the follower of a wrapped increment is dropped
    always_comb begin
        state_d = IOX_RUN;
        ex_d = instr;
        case (state_q)
            IOX_SKIP: begin
                // No-op slot; the next fetched word proceeds
                state_d = IOX_RUN;
            end
            default: begin
                if (do_exec && take_skip) begin
                    state_d = IOX_SKIP;
                    ex_d = '0;
                end
            end
        endcase
    end

    // Pipeline registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= IOX_RUN;
            ex_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            ex_q <= ex_d;
        end
    end

    // ----------------------------------------------------------------
    // Accumulator, status and file write
    // ----------------------------------------------------------------
    // Commit the result of the word in execute
    always_comb begin
        acc_d = acc_q;
        nil_d = nil_q; // Increment keeps flags
        fwr_d = '0;
        retire_d = 1'b0;
        if (state_q == IOX_SKIP) begin
            retire_d = 1'b1;
        end else if (do_exec) begin
            retire_d = 1'b1;
            if (op == iox_pkg::IOX_OP_ORLIT ||
                op == iox_pkg::IOX_OP_ORREG) begin
                nil_d = res_nil;
            end
            if (wr_acc) begin
                acc_d = result;
            end
            if (wr_file) begin
                fwr_d.en = 1'b1;
                fwr_d.addr = fld_addr;
                fwr_d.data = result;
            end
        end
    end

    // Architectural and output registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= `IOX_ACC_RST;
            nil_q <= `IOX_NIL_RST;
            fwr_q <= '0;
            retire_q <= 1'b0;
        end else if (ce) begin
            acc_q <= acc_d;
            nil_q <= nil_d;
            fwr_q <= fwr_d;
            retire_q <= retire_d;
        end
    end

    // Outputs straight from flip-flops
    assign acc = acc_q;
    assign nil_flag = nil_q;
    assign skip = (state_q == IOX_SKIP);
    assign retire = retire_q;
    assign fwr = fwr_q;
    assign rd_addr = ex_q.word[`IOX_ADDR_MSB:0];

endmodule : iox_exec

/* File: logic/iox_defines.svh */
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH

// ----------------------------------------------------------------
// Opcode patterns and field positions
// ----------------------------------------------------------------
`define IOX_INCSKIP_MASK 12'hFC0
`define IOX_INCSKIP_PAT 12'h3C0
`define IOX_ORREG_MASK 12'hFC0
`define IOX_ORREG_PAT 12'h100
`define IOX_ORLIT_MASK 12'hF00
`define IOX_ORLIT_PAT 12'hD00
`define IOX_DEST_BIT 5
`define IOX_ADDR_MSB 4
`define IOX_LIT_MSB 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IOX_ACC_RST 8'h00
`define IOX_NIL_RST 1'h0
`define IOX_FILE_RST 8'h00
`define IOX_FILE_DEPTH 32

`endif

/* File: logic/iox_pkg.sv */
package iox_pkg;

    // Decoded operation class
    typedef enum logic [1:0] {
        IOX_OP_OTHER = 2'b00,
        IOX_OP_INCSKIP = 2'b01,
        IOX_OP_ORLIT = 2'b10,
        IOX_OP_ORREG = 2'b11
    } iox_op_e;

    // Instruction slot handed in by fetch
    typedef struct packed {
        logic valid;
        logic [11:0] word;
    } iox_instr_s;

    // File write request toward the register file
    typedef struct packed {
        logic en;
        logic [4:0] addr;
        logic [7:0] data;
    } iox_fwr_s;

endpackage : iox_pkg

/* File: logic/iox_file_mem.sv */
`timescale 1ns/100ps
`include "iox_defines.svh"

module iox_file_mem (
    input wire logic ref_clk, // Core clock
    input wire logic sys_rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic [4:0] rd_addr, // Read address
    output logic [7:0] rd_data, // Registered read data
    input wire iox_pkg::iox_fwr_s wr // Write request
);

    logic [7:0] mem_q [`IOX_FILE_DEPTH];
    logic [7:0] rd_data_q;

    // ----------------------------------------------------------------
    // Storage and registered read, write-first
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `IOX_FILE_DEPTH; i++) begin
                mem_q[i] <= `IOX_FILE_RST;
            end
            rd_data_q <= `IOX_FILE_RST;
        end else if (ce) begin
            if (wr.en) begin
                mem_q[wr.addr] <= wr.data;
            end
            if (wr.en && wr.addr == rd_addr) begin
                rd_data_q <= wr.data;
            end else begin
                rd_data_q <= mem_q[rd_addr];
            end
        end
    end

    assign rd_data = rd_data_q;

endmodule : iox_file_mem

/* File: tb/iox_exec_props.sv */
`timescale 1ns/100ps
module iox_exec_chk (
    input wire logic ref_clk, // Core clock
    input wire logic sys_rst, // Async reset
    input wire logic ce, // Clock enable
    input wire iox_pkg::iox_instr_s instr, // Fetched word
    input wire logic [4:0] rd_addr, // Read address
    input wire logic [7:0] acc, // Accumulator
    input wire logic nil_flag, // Nil flag
    input wire logic skip, // No-op slot
    input wire logic retire, // Retire pulse
    input wire iox_pkg::iox_fwr_s fwr // File write
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Enabled no-op slot left by the dropped follower
    sequence slot_s;
        skip && ce;
    endsequence
    acc_freeze_a: assert property (!ce |=> $stable(acc))
        else $error("acc moved with ce low");
    nil_freeze_a: assert property (!ce |=> $stable(nil_flag))
        else $error("nil moved with ce low");
    skip_freeze_a: assert property (!ce |=> $stable(skip))
        else $error("skip moved with ce low");
    slot_single_a: assert property (slot_s |=> !skip)
        else $error("no-op slot too long");
    slot_retire_a: assert property (slot_s |=> retire)
        else $error("no-op slot not retired");
    slot_noop_a: assert property (
        slot_s |=> $stable(acc) && $stable(nil_flag))
        else $error("dropped word had effect");
    nil_zero_a: assert property ($rose(nil_flag) |-> acc == 8'h00)
        else $error("nil set with nonzero acc");
    skip_keeps_nil_a: assert property ($rose(skip) |-> $stable(nil_flag))
        else $error("increment changed nil");
    reset_vals_a: assert property ($fell(sys_rst) |->
        acc == 8'h00 && !nil_flag && !skip && !fwr.en)
        else $error("bad reset values");
endmodule : iox_exec_chk
bind iox_exec iox_exec_chk chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ce(ce), .instr(instr), .rd_addr(rd_addr), .acc(acc),
    .nil_flag(nil_flag), .skip(skip), .retire(retire), .fwr(fwr));

/* File: tb/iox_exec_test.sv */
`timescale 1ns/100ps
module iox_exec_test;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    iox_pkg::iox_instr_s instr = '0;
    logic [4:0] rd_addr;
    logic [7:0] acc;
    logic nil_flag, skip, retire, wr_seen, skip_seen;
    iox_pkg::iox_fwr_s fwr, wr_q;
    int bad_count = 0;
    int num_checks = 0;
    int ret_cnt = 0;
    logic [4:0] ra_q;
    // Core clock, 100 MHz
    always #5 ref_clk = ~ref_clk;
    iox_exec dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
        .instr(instr), .rd_addr(rd_addr), .acc(acc), .nil_flag(nil_flag),
        .skip(skip), .retire(retire), .fwr(fwr));
    // Compare a byte result
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    // Compare a flag result
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
        end
    endtask : chk1
    // Send a word and its follower, then log writes and skips
    task automatic issue(input logic [11:0] w, input logic nv,
        input logic [11:0] nw);
        wr_seen = 1'b0;
        skip_seen = 1'b0;
        ret_cnt = 0;
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            #1;
            instr = (i == 0) ? {1'b1, w} : (i == 1) ? {nv, nw} : 13'h0000;
            if (fwr.en === 1'b1) begin
                wr_seen = 1'b1;
                wr_q = fwr;
            end
            if (skip === 1'b1) skip_seen = 1'b1;
            if (retire === 1'b1) ret_cnt++;
            if (i == 1) ra_q = rd_addr;
        end
    endtask : issue
    // Wrap skip drops only the follower; the next word runs
    task automatic t_skip_next();
        logic [11:0] seq [5];
        seq = '{12'hDFF, 12'h127, 12'h3C7, 12'hD01, 12'hD02};
        skip_seen = 1'b0;
        ret_cnt = 0;
        for (int i = 0; i < 9; i++) begin
            @(posedge ref_clk);
            #1;
            instr = (i < 5) ? {1'b1, seq[i]} : 13'h0000;
            if (retire === 1'b1) ret_cnt++;
            if (skip === 1'b1) skip_seen = 1'b1;
        end
        chk8(acc, 8'h02);
        chk1(skip_seen, 1'b1);
        chk8(ret_cnt[7:0], 8'h05);
        chk1(nil_flag, 1'b0);
        $display("t_skip_next done");
    endtask : t_skip_next
    // Literal OR into the accumulator
    task automatic t_orlit();
        issue(12'hD00, 1'b0, 12'h000);
        chk1(nil_flag, 1'b1);
        issue(12'hD9A, 1'b1, 12'hD35);
        chk8(acc, 8'hBF);
        chk1(nil_flag, 1'b0);
        chk1(wr_seen, 1'b0);
        chk8(ret_cnt[7:0], 8'h02);
        $display("t_orlit done");
    endtask : t_orlit
    // Register OR to file and to accumulator
    task automatic t_orreg();
        issue(12'h124, 1'b0, 12'h000);
        chk1(wr_seen, 1'b1);
        chk8({3'h0, ra_q}, 8'h04);
        chk8({3'h0, wr_q.addr}, 8'h04);
        chk8(wr_q.data, 8'hBF);
        issue(12'h105, 1'b0, 12'h000);
        chk8(acc, 8'hBF);
        chk1(wr_seen, 1'b0);
        $display("t_orreg done");
    endtask : t_orreg
    // Increment without skip, both destinations
    task automatic t_inc();
        issue(12'h3E4, 1'b0, 12'h000);
        chk8(wr_q.data, 8'hC0);
        chk8({3'h0, ra_q}, 8'h04);
        chk8(ret_cnt[7:0], 8'h01);
        chk8(acc, 8'hBF);
        chk1(skip_seen, 1'b0);
        issue(12'h3C4, 1'b0, 12'h000);
        chk8(acc, 8'hC1);
        chk1(nil_flag, 1'b0);
        chk1(wr_seen, 1'b0);
        $display("t_inc done");
    endtask : t_inc
    // Wrap to zero skips the follower; ce low freezes
    task automatic t_skip();
        issue(12'hDFF, 1'b1, 12'h123);
        issue(12'h3E3, 1'b1, 12'h123);
        chk1(skip_seen, 1'b1);
        chk8({3'h0, wr_q.addr}, 8'h03);
        chk8(wr_q.data, 8'h00);
        chk8(ret_cnt[7:0], 8'h02);
        chk1(nil_flag, 1'b0);
        issue(12'h3C3, 1'b1, 12'hD10);
        chk8(acc, 8'h11);
        chk1(skip_seen, 1'b0);
        issue(12'h104, 1'b0, 12'h000);
        chk8(acc, 8'hD1);
        ce = 1'b0;
        issue(12'hD20, 1'b0, 12'h000);
        chk8(acc, 8'hD1);
        chk8(ret_cnt[7:0], 8'h00);
        ce = 1'b1;
        $display("t_skip done");
    endtask : t_skip
    // Print counts and verdict
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // Reset for ten cycles, then run the scenarios
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        t_orlit();
        t_orreg();
        t_inc();
        t_skip();
        t_skip_next();
        results();
    end
endmodule : iox_exec_test
